// ==== shared/csoc_regs.svh ====
// Register offsets, reset values and timing constants for the settle/offset block
`ifndef CSOC_REGS_SVH
`define CSOC_REGS_SVH
`define CSOC_ADDR_CH3_FREQ_OFFSET 8'h0f
`define CSOC_ADDR_CH0_SETTLE_COUNT 8'h10
`define CSOC_ADDR_CH1_SETTLE_COUNT 8'h11
`define CSOC_ADDR_CH2_SETTLE_COUNT 8'h12
`define CSOC_ADDR_CH3_SETTLE_COUNT 8'h13
`define CSOC_RST_FREQ_OFFSET 16'h0000
`define CSOC_RST_SETTLE_COUNT 16'h0000
`define CSOC_SETTLE_MIN_PERIODS 20'h0_0020
`define CSOC_SETTLE_SCALE_SH 4
`define CSOC_SETTLE_SMALL_LIMIT 16'h0002
`endif

// ==== shared/csoc_pkg.sv ====
// Types shared by the settle/offset configuration block
package csoc_pkg;
  typedef struct packed {
    logic [15:0] settle;
    logic [9:0] ref_div;
  } csoc_chan_cfg_s;
  typedef struct packed {
    logic conv_start;
    logic amp_err;
  } csoc_chan_evt_s;
  typedef enum logic {CSOC_IDLE, CSOC_SETTLE} csoc_state_e;
endpackage : csoc_pkg

// ==== rtl/csoc_settle_chan.sv ====
// One channel: reference clock enable and settle timer ahead of a conversion
`timescale 1ns/1ns
`default_nettype none
`include "csoc_regs.svh"
module csoc_settle_chan
  import csoc_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire csoc_chan_cfg_s cfg,
  input wire logic conv_req,
  input wire logic amp_ok,
  input wire logic amp_err_en,
  output csoc_chan_evt_s evt,
  output logic ref_tick,
  output logic busy
);
  logic [9:0] div_cnt;
  logic [19:0] target;
  logic [19:0] tick_cnt;
  logic done;
  csoc_state_e state;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      div_cnt <= 10'h000;
    end else if (cfg.ref_div <= 10'h001 || div_cnt >= cfg.ref_div - 10'h001) begin
      div_cnt <= 10'h000;
    end else begin
      div_cnt <= div_cnt + 10'h001;
    end
  end
  assign ref_tick = (div_cnt == 10'h000);

  assign done = (state == CSOC_SETTLE) && ref_tick && (tick_cnt == target - 20'h0_0001);
  assign busy = (state == CSOC_SETTLE);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state <= CSOC_IDLE;
      target <= `CSOC_SETTLE_MIN_PERIODS;
      tick_cnt <= 20'h0_0000;
    end else begin
      unique case (state)
        CSOC_IDLE: begin
          if (conv_req) begin
            state <= CSOC_SETTLE;
            tick_cnt <= 20'h0_0000;
            if (cfg.settle < `CSOC_SETTLE_SMALL_LIMIT) begin
              target <= `CSOC_SETTLE_MIN_PERIODS;
            end else begin
              target <= {cfg.settle, 4'h0};
            end
          end
        end
        CSOC_SETTLE: begin
          if (done) begin
            state <= CSOC_IDLE;
          end else if (ref_tick) begin
            tick_cnt <= tick_cnt + 20'h0_0001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      evt <= '0;
    end else begin
      evt.conv_start <= done;
      evt.amp_err <= done && !amp_ok && amp_err_en;
    end
  end

  chk_small_count: assert property (@(posedge mclk) disable iff (!nrst)
    (state == CSOC_IDLE && conv_req && cfg.settle < 16'h0002) |=> target == 20'h0_0020)
    else $error("settle count below two did not give 32 periods");
  chk_scaled_count: assert property (@(posedge mclk) disable iff (!nrst)
    (state == CSOC_IDLE && conv_req && cfg.settle >= 16'h0002)
      |=> target == {$past(cfg.settle), 4'h0})
    else $error("settle interval is not count times sixteen");
  chk_full_range: assert property (@(posedge mclk) disable iff (!nrst)
    (state == CSOC_IDLE && conv_req && cfg.settle == 16'hffff) |=> target == 20'hf_fff0)
    else $error("largest settle count not accepted");
  chk_ref_spacing: assert property (@(posedge mclk) disable iff (!nrst)
    (ref_tick && cfg.ref_div == 10'h003 && $stable(cfg.ref_div)) |=> !ref_tick ##1 !ref_tick)
    else $error("reference enable spacing wrong");
  chk_start_after: assert property (@(posedge mclk) disable iff (!nrst)
    evt.conv_start |-> $past(state == CSOC_SETTLE) && $past(ref_tick))
    else $error("conversion started without a settle wait");
endmodule : csoc_settle_chan
`default_nettype wire

// ==== rtl/csoc_top.sv ====
// Channel settle counts and channel 3 offset: register bank and timing
// Overview of operation
// - Channel 3 offset scales its reference frequency
// - Wait settle interval before each conversion
// - Unsettled amplitude flags error when enabled
// - Counts zero and one give 32 periods
// - Counts two to all-ones are valid
// - Reference clock is master over divider
`timescale 1ns/1ns
`default_nettype none
`include "csoc_regs.svh"
module csoc_top
  import csoc_pkg::*;
#(
  parameter int NUM_CH = 4
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [NUM_CH*10-1:0] ref_divider,
  input wire logic [NUM_CH-1:0] conv_req,
  input wire logic [NUM_CH-1:0] amp_ok,
  input wire logic [NUM_CH-1:0] amp_err_en,
  output logic [NUM_CH-1:0] conv_start,
  output logic [NUM_CH-1:0] amp_err,
  output logic [NUM_CH-1:0] settle_busy,
  output logic [15:0] ch3_freq_offset_value,
  output logic ch3_freq_offset_value_tick
);
  logic [15:0] ch3_freq_offset;
  logic [15:0] settle_count [NUM_CH];
  logic [NUM_CH-1:0] ref_tick;
  logic [15:0] offset_acc;
  logic [16:0] next_acc;
  logic [15:0] next_rdata;
  logic hit;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ch3_freq_offset <= `CSOC_RST_FREQ_OFFSET;
    end else if (reg_wr && reg_addr == `CSOC_ADDR_CH3_FREQ_OFFSET) begin
      ch3_freq_offset <= reg_wdata;
    end
  end
  assign ch3_freq_offset_value = ch3_freq_offset;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        settle_count[i] <= `CSOC_RST_SETTLE_COUNT;
      end
    end else if (reg_wr) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (reg_addr == `CSOC_ADDR_CH0_SETTLE_COUNT + 8'(i)) begin
          settle_count[i] <= reg_wdata;
        end
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 16'h0000;
    hit = 1'b0;
    if (reg_addr == `CSOC_ADDR_CH3_FREQ_OFFSET) begin
      next_rdata = ch3_freq_offset;
      hit = 1'b1;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (reg_addr == `CSOC_ADDR_CH0_SETTLE_COUNT + 8'(i)) begin
        next_rdata = settle_count[i];
        hit = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= hit ? next_rdata : 16'h0000;
      end
    end
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
    csoc_chan_cfg_s cfg;
    csoc_chan_evt_s evt;
    assign cfg = {settle_count[g], ref_divider[g*10 +: 10]};
    csoc_settle_chan u_chan (
      .mclk(mclk),
      .nrst(nrst),
      .cfg(cfg),
      .conv_req(conv_req[g]),
      .amp_ok(amp_ok[g]),
      .amp_err_en(amp_err_en[g]),
      .evt(evt),
      .ref_tick(ref_tick[g]),
      .busy(settle_busy[g])
    );
    assign conv_start[g] = evt.conv_start;
    assign amp_err[g] = evt.amp_err;
  end

  // Offset frequency accumulator on channel 3 reference
  assign next_acc = {1'b0, offset_acc} + {1'b0, ch3_freq_offset};
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      offset_acc <= 16'h0000;
      ch3_freq_offset_value_tick <= 1'b0;
    end else begin
      ch3_freq_offset_value_tick <= ref_tick[NUM_CH-1] && next_acc[16];
      if (ref_tick[NUM_CH-1]) begin
        offset_acc <= next_acc[15:0];
      end
    end
  end

  chk_offset_write: assert property (@(posedge mclk) disable iff (!nrst)
    (reg_wr && reg_addr == 8'h0f) |=> ch3_freq_offset_value == $past(reg_wdata))
    else $error("offset write not stored");
  chk_offset_carry: assert property (@(posedge mclk) disable iff (!nrst)
    ch3_freq_offset_value_tick |-> $past(ref_tick[NUM_CH-1])
      && ($past(offset_acc) + $past(ch3_freq_offset)) > 17'h0_ffff)
    else $error("offset tick without accumulator overflow");
  chk_settle_write: assert property (@(posedge mclk) disable iff (!nrst)
    (reg_wr && reg_addr == 8'h10) |=> settle_count[0] == $past(reg_wdata))
    else $error("channel 0 settle count not stored");
  chk_err_gate: assert property (@(posedge mclk) disable iff (!nrst)
    amp_err[0] |-> conv_start[0] && $past(amp_err_en[0]) && !$past(amp_ok[0]))
    else $error("amplitude error raised without cause");
  chk_err_raise: assert property (@(posedge mclk) disable iff (!nrst)
    settle_busy[1] ##1 (conv_start[1] && $past(amp_err_en[1] && !amp_ok[1]))
      |-> amp_err[1])
    else $error("enabled amplitude error missed");
  chk_min_settle: assert property (@(posedge mclk) disable iff (!nrst)
    ($rose(settle_busy[2]) && ref_divider[29:20] == 10'h001 && settle_count[2] == 16'h0000)
      |-> settle_busy[2] [*8] ##[25:26] conv_start[2])
    else $error("count zero did not settle in 32 periods");
  chk_read_back: assert property (@(posedge mclk) disable iff (!nrst)
    (reg_rd && reg_addr == 8'h0f) |=> reg_rvalid && reg_rdata == $past(ch3_freq_offset))
    else $error("offset readback wrong");

  // Register bank checks
  chk_settle_write1: assert property (@(posedge mclk) disable iff (!nrst)
    (reg_wr && reg_addr == 8'h11) |=> settle_count[1] == $past(reg_wdata))
    else $error("channel 1 settle count not stored");
  chk_settle_write2: assert property (@(posedge mclk) disable iff (!nrst)
    (reg_wr && reg_addr == 8'h12) |=> settle_count[2] == $past(reg_wdata))
    else $error("channel 2 settle count not stored");
  chk_settle_write3: assert property (@(posedge mclk) disable iff (!nrst)
    (reg_wr && reg_addr == 8'h13) |=> settle_count[3] == $past(reg_wdata))
    else $error("channel 3 settle count not stored");
  chk_read_settle: assert property (@(posedge mclk) disable iff (!nrst)
    (reg_rd && reg_addr == 8'h10) |=> reg_rvalid && reg_rdata == $past(settle_count[0]))
    else $error("channel 0 settle readback wrong");
  chk_rvalid_pulse: assert property (@(posedge mclk) disable iff (!nrst)
    reg_rvalid |-> $past(reg_rd))
    else $error("read valid without a read");

  // Amplitude error checks
  chk_err_only_start: assert property (@(posedge mclk) disable iff (!nrst)
    (amp_err & ~conv_start) == '0)
    else $error("amplitude error outside a conversion start");
  chk_err_disabled: assert property (@(posedge mclk) disable iff (!nrst)
    (conv_start[1] && !$past(amp_err_en[1])) |-> !amp_err[1])
    else $error("amplitude error raised while disabled");

  // Settle wait checks
  chk_busy_end0: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(settle_busy[0]) |-> conv_start[0])
    else $error("channel 0 settle ended without a start");
  chk_busy_end1: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(settle_busy[1]) |-> conv_start[1])
    else $error("channel 1 settle ended without a start");
  chk_busy_end2: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(settle_busy[2]) |-> conv_start[2])
    else $error("channel 2 settle ended without a start");
  chk_busy_end3: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(settle_busy[3]) |-> conv_start[3])
    else $error("channel 3 settle ended without a start");
  chk_req_taken0: assert property (@(posedge mclk) disable iff (!nrst)
    (conv_req[0] && !settle_busy[0]) |=> settle_busy[0])
    else $error("channel 0 request not taken");
  chk_req_taken1: assert property (@(posedge mclk) disable iff (!nrst)
    (conv_req[1] && !settle_busy[1]) |=> settle_busy[1])
    else $error("channel 1 request not taken");
  chk_req_taken2: assert property (@(posedge mclk) disable iff (!nrst)
    (conv_req[2] && !settle_busy[2]) |=> settle_busy[2])
    else $error("channel 2 request not taken");
  chk_req_taken3: assert property (@(posedge mclk) disable iff (!nrst)
    (conv_req[3] && !settle_busy[3]) |=> settle_busy[3])
    else $error("channel 3 request not taken");

  // Reference and offset checks
  chk_div_zero0: assert property (@(posedge mclk) disable iff (!nrst)
    (ref_divider[9:0] <= 10'h001 && $past(ref_divider[9:0]) <= 10'h001) |-> ref_tick[0])
    else $error("channel 0 divide by one not every cycle");
  chk_div_zero3: assert property (@(posedge mclk) disable iff (!nrst)
    (ref_divider[39:30] <= 10'h001 && $past(ref_divider[39:30]) <= 10'h001) |-> ref_tick[3])
    else $error("channel 3 divide by one not every cycle");
  chk_offset_idle: assert property (@(posedge mclk) disable iff (!nrst)
    ch3_freq_offset == 16'h0000 |=> !ch3_freq_offset_value_tick)
    else $error("offset tick with zero offset");
  chk_offset_hold: assert property (@(posedge mclk) disable iff (!nrst)
    !ref_tick[NUM_CH-1] |=> $stable(offset_acc))
    else $error("offset accumulator moved off the reference tick");

  cov_offset_tick: cover property (@(posedge mclk) disable iff (!nrst) ch3_freq_offset_value_tick);
  cov_conv_start: cover property (@(posedge mclk) disable iff (!nrst) conv_start[0]);
  cov_amp_err: cover property (@(posedge mclk) disable iff (!nrst) amp_err[3]);
  cov_unmapped_rd: cover property (@(posedge mclk) disable iff (!nrst)
    reg_rd && reg_addr == 8'h20);
  cov_long_settle: cover property (@(posedge mclk) disable iff (!nrst)
    settle_busy[3] && ref_divider[39:30] == 10'h003);
endmodule : csoc_top
`default_nettype wire

// ==== tb/csoc_host_model.sv ====
// Host model: register writes and reads over the strobe port
`timescale 1ns/1ns
`default_nettype none
module csoc_host_model (
  input wire logic mclk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    // Stale data is inverted so it is never mistaken for a live write
    reg_wdata = ~d;
  endtask : wr
  task rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    // Read valid stands only in the cycle after the read edge; read data holds until the next read
    d = reg_rvalid === 1'b1 ? reg_rdata : 16'hxxxx;
    reg_rd = 1'b0;
  endtask : rd
endmodule : csoc_host_model
`default_nettype wire

// ==== tb/tb_channel_settle_offset_config.sv ====
// Testbench: register bank, settle timing, amplitude errors, offset ticks
`timescale 1ns/1ns
`default_nettype none
module tb_channel_settle_offset_config;
  import csoc_pkg::*;
  logic mclk, nrst, reg_wr, reg_rd, reg_rvalid, ch3_freq_offset_value_tick;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, ch3_freq_offset_value, rv;
  logic [39:0] ref_divider;
  logic [3:0] conv_req, amp_ok, amp_err_en, conv_start, amp_err, settle_busy;
  logic e;
  int err_total, comparisons;
  csoc_top #(.NUM_CH(4)) uut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .ref_divider(ref_divider), .conv_req(conv_req),
    .amp_ok(amp_ok), .amp_err_en(amp_err_en), .conv_start(conv_start),
    .amp_err(amp_err), .settle_busy(settle_busy),
    .ch3_freq_offset_value(ch3_freq_offset_value), .ch3_freq_offset_value_tick(ch3_freq_offset_value_tick));
  csoc_host_model host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk
  task meas(input int ch, input int lo, input int hi, output logic err);
    int n;
    @(negedge mclk);
    conv_req[ch] = 1'b1;
    @(negedge mclk);
    conv_req[ch] = 1'b0;
    chk(16'(settle_busy[ch]), 16'h0001);
    n = 1;
    while (conv_start[ch] !== 1'b1 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    err = amp_err[ch];
    comparisons++;
    if (n < lo || n > hi) begin
      err_total++;
      $display("[ERR] %0t settle took %0d cycles on channel %0d", $time, n, ch);
    end
  endtask : meas
  task t_regs;
    for (int i = 0; i < 5; i++) begin
      host.rd(8'h0f + 8'(i), rv);
      chk(rv, 16'h0000);
      host.wr(8'h0f + 8'(i), 16'ha5c0 + 16'(i));
    end
    host.wr(8'h20, 16'hffff);
    for (int i = 0; i < 5; i++) begin
      host.rd(8'h0f + 8'(i), rv);
      chk(rv, 16'ha5c0 + 16'(i));
    end
    host.rd(8'h20, rv);
    chk(rv, 16'h0000);
    chk(ch3_freq_offset_value, 16'ha5c0);
    $display("t_regs done");
  endtask : t_regs
  task t_settle;
    int exp [4] = '{33, 33, 33, 49};
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h10 + 8'(i), 16'(i));
      meas(i, exp[i], exp[i], e);
    end
    host.wr(8'h12, 16'h0000);
    meas(2, 33, 33, e);
    ref_divider[39:30] = 10'h003;
    host.wr(8'h13, 16'h0005);
    meas(3, 239, 241, e);
    $display("t_settle done");
  endtask : t_settle
  task t_long;
    int n;
    host.wr(8'h13, 16'hffff);
    @(negedge mclk);
    conv_req[3] = 1'b1;
    @(negedge mclk);
    conv_req[3] = 1'b0;
    n = 0;
    repeat (1000) begin
      @(negedge mclk);
      n += int'(settle_busy[3] === 1'b1 && conv_start[3] === 1'b0);
    end
    chk(16'(n), 16'h03e8);
    // Full-scale wait is far too long to finish; cut it short by a reset
    nrst = 1'b0;
    ref_divider[39:30] = 10'h001;
    repeat (4) @(negedge mclk);
    nrst = 1'b1;
    chk(16'(settle_busy[3]), 16'h0000);
    chk(ch3_freq_offset_value, 16'h0000);
    host.rd(8'h13, rv);
    chk(rv, 16'h0000);
    $display("t_long done");
  endtask : t_long
  task t_amp;
    host.wr(8'h11, 16'h0000);
    amp_ok[1] = 1'b0;
    meas(1, 33, 33, e);
    chk(16'(e), 16'h0001);
    amp_err_en[1] = 1'b0;
    meas(1, 33, 33, e);
    chk(16'(e), 16'h0000);
    amp_ok[1] = 1'b1;
    amp_err_en[1] = 1'b1;
    meas(1, 33, 33, e);
    chk(16'(e), 16'h0000);
    $display("t_amp done");
  endtask : t_amp
  task t_offset;
    int n;
    host.wr(8'h0f, 16'h8000);
    n = 0;
    repeat (512) begin
      @(negedge mclk);
      n += int'(ch3_freq_offset_value_tick === 1'b1);
    end
    comparisons++;
    if (n < 255 || n > 257) begin
      err_total++;
      $display("[ERR] %0t offset ticks %0d", $time, n);
    end
    $display("t_offset done");
  endtask : t_offset
  task finish_test;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    // Tests need about 2100 cycles; allow generous margin
    #(8 * 20000);
    err_total++;
    finish_test();
  end
  initial begin
    nrst = 1'b0;
    ref_divider = {10'h001, 10'h001, 10'h001, 10'h001};
    conv_req = 4'h0;
    amp_ok = 4'hf;
    amp_err_en = 4'hf;
    err_total = 0;
    comparisons = 0;
    repeat (20) @(negedge mclk);
    nrst = 1'b1;
    t_regs();
    t_settle();
    t_long();
    t_amp();
    t_offset();
    finish_test();
  end
endmodule : tb_channel_settle_offset_config
`default_nettype wire
